// >>> verilog/ocd_pkg.sv
// Operation
// - the instruction clock is the system clock divided by two.
// - at power-on reset the 3-bit initial source field picks the source.
// - after reset clock switching may change the running source.
// - an erased device reads 111 with two-speed set: it starts on fast rc, then runs fast rc divided by n.
// - the 2-bit primary mode field picks off, fast, standard or external.
// - sources 010 and 011 use the primary mode, 011 with the pll; others ignore mode.
// - outside crystal modes the pin bit picks clock out (1) or gpio (0).
// - the switch/monitor field 1x disables both, 01 switching, 00 both.
// - two-speed start-up runs fast rc until the selected source is ready.
// - the one-shot bit allows one pin-map change, else any number.
// - a read-only 3-bit current source field reports the running source.
package ocd_pkg;
   localparam int CFG_W = 16;
   localparam int SRC_LSB = 0;
   localparam int TWO_SPEED_BIT = 7;
   localparam int PMODE_LSB = 0;
   localparam int PIN_FN_BIT = 2;
   localparam int ONE_SHOT_BIT = 5;
   localparam int SWMON_LSB = 6;
   localparam logic [15:0] SRC_RESERVED_MASK = 16'hff78;
   localparam logic [15:0] MODE_RESERVED_MASK = 16'hff18;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   typedef enum logic [2:0] {
      SRC_FAST_RC = 3'h0,
      SRC_FAST_RC_WITH_PLL = 3'h1,
      SRC_PRIMARY = 3'h2,
      SRC_PRIMARY_PLL = 3'h3,
      SRC_SECONDARY = 3'h4,
      SRC_LOW_POWER_RC = 3'h5,
      SRC_FAST_RC_DIV16 = 3'h6,
      SRC_FAST_RC_DIV_N = 3'h7
   } ocd_src_e;
   localparam logic [1:0] PM_EXTERNAL_CLOCK_IN = 2'h0;
   localparam logic [1:0] PM_STANDARD_CRYSTAL = 2'h1;
   localparam logic [1:0] PM_HIGH_SPEED_CRYSTAL = 2'h2;
   localparam logic [1:0] PM_DISABLED = 2'h3;
endpackage : ocd_pkg

// >>> verilog/ocd_sel_if.sv
`timescale 1ns/1ps
// decoded selections handed from the decoder to the top
interface ocd_sel_if;
   logic [2:0] init_src;
   logic [1:0] primary_mode_sel;
   logic out_pin_function;
   logic switch_en;
   logic fail_safe_monitor_en;
   logic two_speed_startup;
   logic pin_map_one_shot;
   logic reserved_ok;
   modport dec (output init_src, primary_mode_sel, out_pin_function,
      switch_en, fail_safe_monitor_en, two_speed_startup,
      pin_map_one_shot, reserved_ok);
   modport use_side (input init_src, primary_mode_sel, out_pin_function,
      switch_en, fail_safe_monitor_en, two_speed_startup,
      pin_map_one_shot, reserved_ok);
endinterface : ocd_sel_if

// >>> verilog/ocd_field_decode.sv
`timescale 1ns/1ps
// pure field decode of the two configuration words
module ocd_field_decode (
   input wire logic [15:0] src_word_in,
   input wire logic [15:0] mode_word_in,
   ocd_sel_if.dec sel
);
   always_comb begin
      sel.init_src = src_word_in[ocd_pkg::SRC_LSB +: 3];
      sel.two_speed_startup = src_word_in[ocd_pkg::TWO_SPEED_BIT];
      sel.primary_mode_sel = mode_word_in[ocd_pkg::PMODE_LSB +: 2];
      sel.out_pin_function = mode_word_in[ocd_pkg::PIN_FN_BIT];
      sel.pin_map_one_shot = mode_word_in[ocd_pkg::ONE_SHOT_BIT];
      // 1x kills both, 01 switch only, 00 both
      sel.switch_en = ~mode_word_in[ocd_pkg::SWMON_LSB + 1];
      sel.fail_safe_monitor_en =
         (mode_word_in[ocd_pkg::SWMON_LSB +: 2] == 2'h0);
      // flag words whose reserved bits were not left at one
      sel.reserved_ok =
         ((src_word_in & ocd_pkg::SRC_RESERVED_MASK) ==
          ocd_pkg::SRC_RESERVED_MASK) &&
         ((mode_word_in & ocd_pkg::MODE_RESERVED_MASK) ==
          ocd_pkg::MODE_RESERVED_MASK);
   end
endmodule : ocd_field_decode

// >>> verilog/ocd_osc_config_decode.sv
`timescale 1ns/1ps
// samples configuration at power-on reset, runs source selection,
// clock switching requests, two-speed start-up and the fcy divider
module ocd_osc_config_decode (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic [15:0] initial_source_config_in,
   input wire logic [15:0] oscillator_mode_config_in,
   input wire logic src_ready_in,
   input wire logic switch_req_in,
   input wire logic [2:0] switch_src_in,
   input wire logic pin_map_write_in,
   output logic [2:0] current_source_out,
   output logic [1:0] primary_mode_sel_out,
   output logic primary_pll_out,
   output logic fcy_out,
   output logic clock_out_pin_out,
   output logic clock_out_pin_oe_out,
   output logic clock_out_is_gpio_out,
   output logic switch_en_out,
   output logic fail_safe_monitor_en_out,
   output logic pin_map_allowed_out,
   output logic reserved_ok_out,
   output logic startup_busy_out
);
   typedef enum logic [1:0] {ST_SAMPLE, ST_TWO_SPEED, ST_RUN} ocd_st_e;

   ocd_sel_if sel_bus ();

   ocd_field_decode u_dec (
      .src_word_in(initial_source_config_in),
      .mode_word_in(oscillator_mode_config_in),
      .sel(sel_bus.dec)
   );

   // held copy of decoded configuration
   ocd_st_e st_r, st_nxt;
   logic [2:0] init_src_r, init_src_nxt;
   logic [1:0] pmode_r, pmode_nxt;
   logic pin_fn_r, pin_fn_nxt;
   logic sw_en_r, sw_en_nxt;
   logic fsm_en_r, fsm_en_nxt;
   logic two_spd_r, two_spd_nxt;
   logic one_shot_r, one_shot_nxt;
   logic res_ok_r, res_ok_nxt;
   logic [2:0] cur_src_r, cur_src_nxt;
   logic fcy_r, fcy_nxt;
   logic pin_out_r, pin_out_nxt;
   logic pin_oe_r, pin_oe_nxt;
   logic gpio_r, gpio_nxt;
   logic map_used_r, map_used_nxt;
   logic map_ok_r, map_ok_nxt;
   logic rdy_s1_r, rdy_s2_r, rdy_s3_r;
   logic rdy_r, rdy_nxt;
   logic crystal_mode;
   logic pll_r, pll_nxt;
   logic busy_r, busy_nxt;

   // crystal modes own the pin, so no clock output there; judged on
   // next values so the pin never drives fcy for a cycle after sampling,
   // and on both the initial and the running source
   assign crystal_mode =
      ((init_src_nxt == ocd_pkg::SRC_PRIMARY) ||
       (init_src_nxt == ocd_pkg::SRC_PRIMARY_PLL) ||
       (cur_src_nxt == ocd_pkg::SRC_PRIMARY) ||
       (cur_src_nxt == ocd_pkg::SRC_PRIMARY_PLL)) &&
      ((pmode_nxt == ocd_pkg::PM_HIGH_SPEED_CRYSTAL) ||
       (pmode_nxt == ocd_pkg::PM_STANDARD_CRYSTAL));

   // source ready comes from an oscillator domain: three-stage sync
   // so a metastable first stage never reaches the start-up logic
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rdy_s1_r <= 1'b0;
         rdy_s2_r <= 1'b0;
         rdy_s3_r <= 1'b0;
         rdy_r <= 1'b0;
      end else if (clk_en_in) begin
         rdy_s1_r <= src_ready_in;
         rdy_s2_r <= rdy_s1_r;
         rdy_s3_r <= rdy_s2_r;
         rdy_r <= rdy_nxt;
      end
   end

   // filtered level changes only when the last two stages agree
   always_comb begin
      rdy_nxt = rdy_r;
      if (rdy_s2_r == rdy_s3_r) begin
         rdy_nxt = rdy_s3_r;
      end
   end

   // next-state logic for sampling, start-up and switching
   always_comb begin
      st_nxt = st_r;
      init_src_nxt = init_src_r;
      pmode_nxt = pmode_r;
      pin_fn_nxt = pin_fn_r;
      sw_en_nxt = sw_en_r;
      fsm_en_nxt = fsm_en_r;
      two_spd_nxt = two_spd_r;
      one_shot_nxt = one_shot_r;
      res_ok_nxt = res_ok_r;
      cur_src_nxt = cur_src_r;
      map_used_nxt = map_used_r;
      case (st_r)
         ST_SAMPLE: begin
            // one sample after reset, then frozen
            init_src_nxt = sel_bus.init_src;
            pmode_nxt = sel_bus.primary_mode_sel;
            pin_fn_nxt = sel_bus.out_pin_function;
            sw_en_nxt = sel_bus.switch_en;
            fsm_en_nxt = sel_bus.fail_safe_monitor_en;
            two_spd_nxt = sel_bus.two_speed_startup;
            one_shot_nxt = sel_bus.pin_map_one_shot;
            res_ok_nxt = sel_bus.reserved_ok;
            if (sel_bus.two_speed_startup) begin
               cur_src_nxt = ocd_pkg::SRC_FAST_RC;
               st_nxt = ST_TWO_SPEED;
            end else begin
               cur_src_nxt = sel_bus.init_src;
               st_nxt = ST_RUN;
            end
         end
         ST_TWO_SPEED: begin
            // no timeout: a source that never comes ready keeps the
            // block on fast rc, which is the safe place to wait
            if (rdy_r) begin
               cur_src_nxt = init_src_r;
               st_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // switching honoured only when the switch field allows it;
            // the target is not checked against the permitted sources,
            // so the requester must only name oscillators that exist
            if (switch_req_in && sw_en_r) begin
               cur_src_nxt = switch_src_in;
            end
         end
         default: begin
            st_nxt = ST_SAMPLE;
         end
      endcase
      // a refused write leaves the used flag alone
      if (pin_map_write_in && map_ok_r) begin
         map_used_nxt = 1'b1;
      end
   end

   // derived outputs from next state, so they move on the same edge
   // as the selections they depend on
   always_comb begin
      fcy_nxt = ~fcy_r;
      map_ok_nxt = ~(one_shot_nxt && map_used_nxt);
      gpio_nxt = ~crystal_mode && ~pin_fn_nxt;
      pin_oe_nxt = ~crystal_mode && pin_fn_nxt;
      pin_out_nxt = pin_oe_nxt && fcy_nxt;
      // registered so both flags leave the block from a flip-flop
      pll_nxt = (init_src_nxt == ocd_pkg::SRC_PRIMARY_PLL);
      busy_nxt = (st_nxt != ST_RUN);
   end

   // state register; reset wins over a low clock enable so a frozen
   // block still comes back to its power-on state
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_r <= ST_SAMPLE;
         init_src_r <= ocd_pkg::SRC_FAST_RC_DIV_N;
         pmode_r <= ocd_pkg::PM_DISABLED;
         pin_fn_r <= 1'b1;
         sw_en_r <= 1'b0;
         fsm_en_r <= 1'b0;
         two_spd_r <= 1'b0;
         one_shot_r <= 1'b1;
         res_ok_r <= 1'b0;
         cur_src_r <= ocd_pkg::SRC_FAST_RC_DIV_N;
         fcy_r <= 1'b0;
         pin_out_r <= 1'b0;
         pin_oe_r <= 1'b0;
         gpio_r <= 1'b0;
         map_used_r <= 1'b0;
         map_ok_r <= 1'b0;
         pll_r <= 1'b0;
         busy_r <= 1'b1;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
         init_src_r <= init_src_nxt;
         pmode_r <= pmode_nxt;
         pin_fn_r <= pin_fn_nxt;
         sw_en_r <= sw_en_nxt;
         fsm_en_r <= fsm_en_nxt;
         two_spd_r <= two_spd_nxt;
         one_shot_r <= one_shot_nxt;
         res_ok_r <= res_ok_nxt;
         cur_src_r <= cur_src_nxt;
         fcy_r <= fcy_nxt;
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
         gpio_r <= gpio_nxt;
         map_used_r <= map_used_nxt;
         map_ok_r <= map_ok_nxt;
         pll_r <= pll_nxt;
         busy_r <= busy_nxt;
      end
   end

   // every output straight from a flip-flop, no gate behind it, so
   // nothing outside sees a glitch while the selections settle
   assign current_source_out = cur_src_r;
   assign primary_mode_sel_out = pmode_r;
   assign primary_pll_out = pll_r;
   assign fcy_out = fcy_r;
   assign clock_out_pin_out = pin_out_r;
   assign clock_out_pin_oe_out = pin_oe_r;
   assign clock_out_is_gpio_out = gpio_r;
   assign switch_en_out = sw_en_r;
   assign fail_safe_monitor_en_out = fsm_en_r;
   assign pin_map_allowed_out = map_ok_r;
   assign reserved_ok_out = res_ok_r;
   assign startup_busy_out = busy_r;
endmodule : ocd_osc_config_decode

// >>> test/ocd_cfg_mem.sv
`timescale 1ns/1ps
// program-memory image of both configuration words
module ocd_cfg_mem (
   input wire logic prog_in,
   input wire logic [15:0] src_in,
   input wire logic [15:0] mode_in,
   output logic [15:0] src_out,
   output logic [15:0] mode_out
);
   // an unprogrammed part reads all ones; the programmer always fills
   // reserved bits, whatever it was asked for
   initial begin
      src_out = ocd_pkg::ERASED_WORD;
      mode_out = ocd_pkg::ERASED_WORD;
      forever begin
         @(posedge prog_in);
         src_out = src_in | ocd_pkg::SRC_RESERVED_MASK;
         mode_out = mode_in | ocd_pkg::MODE_RESERVED_MASK;
      end
   end
endmodule : ocd_cfg_mem

// >>> test/ocd_properties.sv
`timescale 1ns/1ps
module ocd_props (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic switch_req_in,
   input wire logic [2:0] switch_src_in,
   input wire logic pin_map_write_in,
   input wire logic [2:0] current_source_out,
   input wire logic [1:0] primary_mode_sel_out,
   input wire logic fcy_out,
   input wire logic clock_out_pin_out,
   input wire logic clock_out_pin_oe_out,
   input wire logic clock_out_is_gpio_out,
   input wire logic switch_en_out,
   input wire logic fail_safe_monitor_en_out,
   input wire logic pin_map_allowed_out,
   input wire logic startup_busy_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   // settled run state, three cycles clear of the sampling edges
   sequence run3;
      (!startup_busy_out)[*3];
   endsequence
   fcy_div_a: assert property (clk_en_in |=> fcy_out != $past(fcy_out))
      else $error("fcy did not toggle");
   fcy_hold_a: assert property (!clk_en_in |=> $stable(fcy_out))
      else $error("fcy moved while disabled");
   monitor_needs_sw_a: assert property (
      fail_safe_monitor_en_out |-> switch_en_out)
      else $error("monitor on without switching");
   pin_dir_a: assert property (
      clock_out_pin_oe_out |-> !clock_out_is_gpio_out)
      else $error("pin both clock and gpio");
   crystal_pin_a: assert property (
      primary_mode_sel_out inside {2'h1, 2'h2} &&
      current_source_out inside {3'h2, 3'h3} |-> !clock_out_pin_oe_out)
      else $error("clock driven in crystal mode");
   pin_clock_a: assert property (
      clock_out_pin_out == (clock_out_pin_oe_out && fcy_out))
      else $error("pin does not carry fcy");
   cfg_hold_a: assert property (
      run3 |=> $stable(switch_en_out) && $stable(primary_mode_sel_out))
      else $error("decoded config moved");
   no_switch_a: assert property (
      run3 ##0 !switch_en_out |=> $stable(current_source_out))
      else $error("source moved while locked");
   switch_take_a: assert property (
      !startup_busy_out && switch_en_out && clk_en_in && switch_req_in |=>
      current_source_out == $past(switch_src_in))
      else $error("switch not taken");
   pin_map_a: assert property (
      $fell(pin_map_allowed_out) |-> $past(pin_map_write_in))
      else $error("pin map lock without write");
   sw_c: cover property (switch_en_out && switch_req_in && !startup_busy_out);
   boot_c: cover property ($fell(startup_busy_out));
   lock_c: cover property ($fell(pin_map_allowed_out));
endmodule : ocd_props
bind ocd_osc_config_decode ocd_props u_props (.core_clk_in, .sys_rst_in,
   .clk_en_in, .switch_req_in, .switch_src_in, .pin_map_write_in,
   .current_source_out, .primary_mode_sel_out, .fcy_out, .clock_out_pin_out,
   .clock_out_pin_oe_out, .clock_out_is_gpio_out, .switch_en_out,
   .fail_safe_monitor_en_out, .pin_map_allowed_out, .startup_busy_out);

// >>> test/ocd_osc_config_decode_tb_top.sv
`timescale 1ns/1ps
module ocd_osc_config_decode_tb_top;
   logic core_clk_in = 0, sys_rst_in = 1, clk_en_in = 1, src_ready_in = 1;
   logic switch_req_in = 0, pin_map_write_in = 0, prog = 0;
   logic [2:0] switch_src_in = 0, current_source_out;
   logic [15:0] pw_s = 0, pw_m = 0;
   logic [15:0] initial_source_config_in, oscillator_mode_config_in;
   logic [1:0] primary_mode_sel_out;
   logic primary_pll_out, fcy_out, clock_out_pin_out, clock_out_pin_oe_out;
   logic clock_out_is_gpio_out, switch_en_out, fail_safe_monitor_en_out;
   logic pin_map_allowed_out, reserved_ok_out, startup_busy_out;
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #20 core_clk_in = ~core_clk_in;
   ocd_cfg_mem MEM (.prog_in(prog), .src_in(pw_s), .mode_in(pw_m),
      .src_out(initial_source_config_in),
      .mode_out(oscillator_mode_config_in));
   ocd_osc_config_decode DUT (.core_clk_in, .sys_rst_in, .clk_en_in,
      .initial_source_config_in, .oscillator_mode_config_in, .src_ready_in,
      .switch_req_in, .switch_src_in, .pin_map_write_in, .current_source_out,
      .primary_mode_sel_out, .primary_pll_out, .fcy_out, .clock_out_pin_out,
      .clock_out_pin_oe_out, .clock_out_is_gpio_out, .switch_en_out,
      .fail_safe_monitor_en_out, .pin_map_allowed_out, .reserved_ok_out,
      .startup_busy_out);
   task automatic complete_run;
      $display("checks %0d n_errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // program, power-on reset for 8 cycles, then let sampling settle
   task automatic boot(logic [15:0] s, logic [15:0] m);
      @(negedge core_clk_in);
      sys_rst_in = 1;
      pw_s = s;
      pw_m = m;
      prog = 1;
      repeat (8) @(negedge core_clk_in);
      prog = 0;
      chk("rst_src", 7, current_source_out);
      sys_rst_in = 0;
      repeat (4) @(negedge core_clk_in);
   endtask : boot
   task automatic cyc_pulse(ref logic sig);
      sig = 1;
      @(negedge core_clk_in);
      sig = 0;
      @(negedge core_clk_in);
   endtask : cyc_pulse
   task automatic t_erased;
      logic p;
      boot(16'hffff, 16'hffff);
      repeat (8) @(negedge core_clk_in);
      chk("src", 7, current_source_out);
      chk("resv", 1, reserved_ok_out);
      chk("oe", 1, clock_out_pin_oe_out);
      chk("sw", 0, switch_en_out);
      // fcy must show on the pin and move every cycle
      p = clock_out_pin_out;
      @(negedge core_clk_in);
      chk("pin", {3'b000, ~p}, clock_out_pin_out);
   endtask : t_erased
   task automatic t_sources;
      for (int s = 0; s < 8; s++) begin
         boot(s[15:0], 16'h0004);
         chk("src", s[3:0], current_source_out);
         chk("pll", {3'b000, s == 3}, primary_pll_out);
      end
   endtask : t_sources
   // every mode and switch/monitor code, then a switch attempt
   task automatic t_fields;
      for (int i = 0; i < 4; i++) begin
         boot(16'h0002, {8'h00, i[1:0], 3'b000, i[0], i[1:0]});
         chk("mode", i[3:0], primary_mode_sel_out);
         chk("sw", {3'b000, !i[1]}, switch_en_out);
         chk("fsm", {3'b000, i == 0}, fail_safe_monitor_en_out);
         chk("oe", {3'b000, i == 3}, clock_out_pin_oe_out);
         if (i == 0) chk("gpio", 1, clock_out_is_gpio_out);
         if (i != 3) chk("pin0", 0, clock_out_pin_out);
         switch_src_in = 5;
         cyc_pulse(switch_req_in);
         chk("swsrc", i[1] ? 4'h2 : 4'h5, current_source_out);
      end
   endtask : t_fields
   task automatic t_b2b;
      boot(16'h0000, 16'h0004);
      switch_src_in = 4;
      switch_req_in = 1;
      @(negedge core_clk_in);
      chk("b2b1", 4, current_source_out);
      switch_src_in = 1;
      @(negedge core_clk_in);
      switch_req_in = 0;
      clk_en_in = 0;
      chk("b2b2", 1, current_source_out);
      repeat (3) @(negedge core_clk_in);
      clk_en_in = 1;
   endtask : t_b2b
   task automatic t_two_speed;
      src_ready_in = 0;
      boot(16'h0082, 16'h0004);
      chk("busy", 1, startup_busy_out);
      chk("frc", 0, current_source_out);
      src_ready_in = 1;
      repeat (10) @(negedge core_clk_in);
      chk("sel", 2, current_source_out);
      chk("busy", 0, startup_busy_out);
   endtask : t_two_speed
   task automatic t_pin_map;
      for (int i = 0; i < 2; i++) begin
         boot(16'h0000, {10'h000, i[0], 5'b00100});
         chk("pm0", 1, pin_map_allowed_out);
         cyc_pulse(pin_map_write_in);
         cyc_pulse(pin_map_write_in);
         chk("pm2", {3'b000, !i[0]}, pin_map_allowed_out);
      end
   endtask : t_pin_map
   // hang guard, far beyond the few hundred cycles the run needs
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         complete_run;
      end
   end
   initial begin
      t_erased;
      t_sources;
      t_fields;
      t_b2b;
      t_two_speed;
      t_pin_map;
      complete_run;
   end
endmodule : ocd_osc_config_decode_tb_top
